// *** shared/sles_pkg.sv ***
package sles_pkg;

   localparam int          SLES_LANES      = 4;
   localparam int          SLES_FIRST_LANE = 4;
   localparam int          SLES_KINDS      = 3;
   localparam int          SLES_ADDR_W     = 12;
   localparam int          SLES_DATA_W     = 8;
   localparam int          SLES_CNT_W      = 8;

   // Byte addresses of the four lane status registers
   localparam logic [11:0] SLES_LANE4_ERROR_STATUS = 12'h494;
   localparam logic [11:0] SLES_LANE5_ERROR_STATUS = 12'h495;
   localparam logic [11:0] SLES_LANE6_ERROR_STATUS = 12'h496;
   localparam logic [11:0] SLES_LANE7_ERROR_STATUS = 12'h497;

   // Field positions within a status register
   localparam int          SLES_ACTIVE_BIT = 3;
   localparam int          SLES_UEK_BIT    = 2;
   localparam int          SLES_NIT_BIT    = 1;
   localparam int          SLES_BDE_BIT    = 0;

   localparam logic [7:0]  SLES_STATUS_RESET = 8'h00;
   localparam logic [7:0]  SLES_CNT_TERMINAL = 8'hff;
   localparam logic [7:0]  SLES_CNT_ZERO     = 8'h00;
   localparam logic [7:0]  SLES_CNT_ONE      = 8'h01;
   localparam logic [3:0]  SLES_RSVD_VALUE   = 4'h0;

   // Layout of one lane status register
   typedef struct packed {
      logic [3:0] reserved;
      logic       active;
      logic [2:0] count_full;
   } sles_status_t;

   // Per-lane inputs from the lane decoder and configuration
   typedef struct packed {
      logic       active;
      logic [2:0] error;
      logic [2:0] hold;
      logic [2:0] clear;
   } sles_lane_in_t;

endpackage

// *** rtl/sles_err_counter.sv ***
`timescale 1ns/10ps
module sles_err_counter
   import sles_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       cnt_event,
   input  wire logic       cnt_hold,
   input  wire logic       cnt_clear,
   // Result
   output logic [7:0]      count,
   output logic            count_full
);

   logic [7:0] next_count;
   logic [7:0] bumped;
   logic       at_terminal;
   logic       hit;
   logic       next_full;

   assign at_terminal = (count == SLES_CNT_TERMINAL);
   // Held at terminal when saturation is enabled, else wraps through zero
   assign bumped      = (at_terminal && cnt_hold) ? SLES_CNT_TERMINAL
                                                  : 8'(count + SLES_CNT_ONE);
   // An error in the clear cycle still counts, so it is never lost
   assign next_count  = cnt_clear ? (cnt_event ? SLES_CNT_ONE : SLES_CNT_ZERO)
                                  : (cnt_event ? bumped : count);
   assign hit         = !cnt_clear && cnt_event && (bumped == SLES_CNT_TERMINAL) && !at_terminal;
   // Clear wins over set
   assign next_full   = hit || (count_full && !cnt_clear);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count      <= SLES_CNT_ZERO;
         count_full <= 1'b0;
      end else begin
         count      <= next_count;
         count_full <= next_full;
      end
   end

   property p_hold_keeps;
      @(posedge ref_clk) disable iff (!rst_n)
         (at_terminal && cnt_hold && !cnt_clear) |=> (count == SLES_CNT_TERMINAL);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) else $error("held counter left terminal");

   property p_wrap;
      @(posedge ref_clk) disable iff (!rst_n)
         (at_terminal && !cnt_hold && cnt_event && !cnt_clear) |=> (count == SLES_CNT_ZERO);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_full_on_terminal;
      @(posedge ref_clk) disable iff (!rst_n)
         ($changed(count) && count == SLES_CNT_TERMINAL && !$past(cnt_clear)) |-> count_full;
   endproperty
   a_full_on_terminal: assert property (p_full_on_terminal) else $error("flag not set");

endmodule

// *** rtl/sles_top.sv ***
`timescale 1ns/10ps
module sles_top
   import sles_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // Lane decoders, lanes 4 to 7
   input  wire sles_lane_in_t [3:0]       lane_in,
   // Register access port
   input  wire logic [SLES_ADDR_W-1:0]    reg_addr,
   input  wire logic                      reg_rd,
   input  wire logic                      reg_wr,
   input  wire logic [SLES_DATA_W-1:0]    reg_wdata,
   output logic [SLES_DATA_W-1:0]         reg_rdata,
   output logic                           reg_rvalid,
   // Live status, one byte per lane
   output sles_status_t [3:0]             lane_status
);

   logic [7:0]           counts [SLES_LANES][SLES_KINDS];
   logic [2:0]           full_now [SLES_LANES];
   sles_status_t [3:0]   next_status;
   logic [7:0]           next_rdata;
   logic [1:0]           sel_lane;
   logic                 sel_hit;

   genvar l, k;
   generate
      for (l = 0; l < SLES_LANES; l++) begin : g_lane
         for (k = 0; k < SLES_KINDS; k++) begin : g_kind
            // One independent counter per lane and error kind
            sles_err_counter u_cnt (
               .ref_clk    (ref_clk),
               .rst_n      (rst_n),
               .cnt_event  (lane_in[l].error[k]),
               .cnt_hold   (lane_in[l].hold[k]),
               .cnt_clear  (lane_in[l].clear[k]),
               .count      (counts[l][k]),
               .count_full (full_now[l][k])
            );
         end
         assign next_status[l].reserved   = SLES_RSVD_VALUE;
         assign next_status[l].active     = lane_in[l].active;
         assign next_status[l].count_full = full_now[l];
      end
   endgenerate

   // Lanes occupy four consecutive byte addresses
   assign sel_hit    = (reg_addr >= SLES_LANE4_ERROR_STATUS) &&
                       (reg_addr <= SLES_LANE7_ERROR_STATUS);
   assign sel_lane   = 2'(reg_addr - SLES_LANE4_ERROR_STATUS);
   // Unmapped reads answer zero
   assign next_rdata = sel_hit ? lane_status[sel_lane] : SLES_STATUS_RESET;

   // Writes are not decoded; the bank is read-only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lane_status <= {SLES_LANES{SLES_STATUS_RESET}};
         reg_rdata   <= SLES_STATUS_RESET;
         reg_rvalid  <= 1'b0;
      end else begin
         lane_status <= next_status;
         reg_rdata   <= reg_rd ? next_rdata : SLES_STATUS_RESET;
         reg_rvalid  <= reg_rd;
      end
   end

   property p_active_follows;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[0].active == $past(lane_in[0].active) &&
             lane_status[3].active == $past(lane_in[3].active);
   endproperty
   a_active_follows: assert property (p_active_follows) else $error("active bit wrong");

   property p_flag_order;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[1].count_full ==
             {$past(full_now[1][2]), $past(full_now[1][1]), $past(full_now[1][0])};
   endproperty
   a_flag_order: assert property (p_flag_order) else $error("flag order wrong");

   property p_flag_after_terminal;
      @(posedge ref_clk) disable iff (!rst_n)
         ($rose(full_now[2][0])) |=> lane_status[2].count_full[SLES_BDE_BIT];
   endproperty
   a_flag_after_terminal: assert property (p_flag_after_terminal) else $error("flag missing");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rvalid |-> (reg_rdata[7:4] == SLES_RSVD_VALUE);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_write_ignored;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_wr && !reg_rd) |=> !reg_rvalid;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write answered");

   property p_lane_read;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && reg_addr == SLES_LANE5_ERROR_STATUS) |=>
            (reg_rvalid && reg_rdata == $past(lane_status[1]));
   endproperty
   a_lane_read: assert property (p_lane_read) else $error("lane read mismatch");

   property p_reset_zero;
      @(posedge ref_clk)
         !rst_n |=> (lane_status == '0 && !reg_rvalid && reg_rdata == SLES_STATUS_RESET);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

   // Middle lanes, so every lane's active bit is watched
   property p_active_lane1;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[1].active == $past(lane_in[1].active);
   endproperty
   a_active_lane1: assert property (p_active_lane1) else $error("lane1 active wrong");

   property p_active_lane2;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[2].active == $past(lane_in[2].active);
   endproperty
   a_active_lane2: assert property (p_active_lane2) else $error("lane2 active wrong");

   property p_flag_order_lane0;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[0].count_full ==
             {$past(full_now[0][2]), $past(full_now[0][1]), $past(full_now[0][0])};
   endproperty
   a_flag_order_lane0: assert property (p_flag_order_lane0) else $error("lane0 flags");

   property p_flag_order_lane2;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[2].count_full ==
             {$past(full_now[2][2]), $past(full_now[2][1]), $past(full_now[2][0])};
   endproperty
   a_flag_order_lane2: assert property (p_flag_order_lane2) else $error("lane2 flags");

   property p_flag_order_lane3;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 lane_status[3].count_full ==
             {$past(full_now[3][2]), $past(full_now[3][1]), $past(full_now[3][0])};
   endproperty
   a_flag_order_lane3: assert property (p_flag_order_lane3) else $error("lane3 flags");

   // Each address must return its own lane, not a neighbour
   property p_lane4_read;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && reg_addr == SLES_LANE4_ERROR_STATUS) |=>
            (reg_rvalid && reg_rdata == $past(lane_status[0]));
   endproperty
   a_lane4_read: assert property (p_lane4_read) else $error("lane4 read mismatch");

   property p_lane6_read;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && reg_addr == SLES_LANE6_ERROR_STATUS) |=>
            (reg_rvalid && reg_rdata == $past(lane_status[2]));
   endproperty
   a_lane6_read: assert property (p_lane6_read) else $error("lane6 read mismatch");

   property p_lane7_read;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && reg_addr == SLES_LANE7_ERROR_STATUS) |=>
            (reg_rvalid && reg_rdata == $past(lane_status[3]));
   endproperty
   a_lane7_read: assert property (p_lane7_read) else $error("lane7 read mismatch");

   property p_unmapped_zero;
      @(posedge ref_clk) disable iff (!rst_n)
         (reg_rd && !sel_hit) |=> (reg_rvalid && reg_rdata == SLES_STATUS_RESET);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

   // Idle bus shows zero so stale status never leaks
   property p_idle_rdata_zero;
      @(posedge ref_clk) disable iff (!rst_n)
         !reg_rd |=> (!reg_rvalid && reg_rdata == SLES_STATUS_RESET);
   endproperty
   a_idle_rdata_zero: assert property (p_idle_rdata_zero) else $error("idle data");

   property p_rvalid_follows;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rd |=> reg_rvalid;
   endproperty
   a_rvalid_follows: assert property (p_rvalid_follows) else $error("read not answered");

   property p_status_reserved;
      @(posedge ref_clk) disable iff (!rst_n)
         lane_status[0].reserved == SLES_RSVD_VALUE && lane_status[1].reserved == SLES_RSVD_VALUE &&
         lane_status[2].reserved == SLES_RSVD_VALUE && lane_status[3].reserved == SLES_RSVD_VALUE;
   endproperty
   a_status_reserved: assert property (p_status_reserved) else $error("reserved nibble");

   property p_flag_sticky_lane0;
      @(posedge ref_clk) disable iff (!rst_n)
         (full_now[0][0] && !lane_in[0].clear[0]) |=> full_now[0][0];
   endproperty
   a_flag_sticky_lane0: assert property (p_flag_sticky_lane0) else $error("flag dropped");

   property p_flag_cleared;
      @(posedge ref_clk) disable iff (!rst_n)
         lane_in[1].clear[1] |=> !full_now[1][1];
   endproperty
   a_flag_cleared: assert property (p_flag_cleared) else $error("flag kept on clear");

   // A quiet lane must not see its flags move
   property p_lane_independent;
      @(posedge ref_clk) disable iff (!rst_n)
         (lane_in[0].error == 3'h0 && lane_in[0].clear == 3'h0) |=> $stable(full_now[0]);
   endproperty
   a_lane_independent: assert property (p_lane_independent) else $error("lane crosstalk");

   property p_flag_needs_error;
      @(posedge ref_clk) disable iff (!rst_n)
         $rose(full_now[2][2]) |-> $past(lane_in[2].error[2]);
   endproperty
   a_flag_needs_error: assert property (p_flag_needs_error) else $error("flag without error");

endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import sles_pkg::*;

   logic                ref_clk;
   logic                rst_n;
   sles_lane_in_t [3:0] lane_in;
   logic [11:0]         reg_addr;
   logic                reg_rd;
   logic                reg_wr;
   logic [7:0]          reg_wdata;
   logic [7:0]          reg_rdata;
   logic                reg_rvalid;
   sles_status_t [3:0]  lane_status;
   logic [7:0]          exp_st [4];
   int                  bad_count;
   int                  samples_checked;

   sles_top DUT (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .lane_in     (lane_in),
      .reg_addr    (reg_addr),
      .reg_rd      (reg_rd),
      .reg_wr      (reg_wr),
      .reg_wdata   (reg_wdata),
      .reg_rdata   (reg_rdata),
      .reg_rvalid  (reg_rvalid),
      .lane_status (lane_status)
   );

   always #5 ref_clk = ~ref_clk;

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Inputs move 1 ns after the edge so sampling never races
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      int i;
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) tick();
      if (reg_rvalid !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
      chk("reg_rdata", exp, reg_rdata);
      tick();
   endtask

   task automatic check_all();
      for (int l = 0; l < 4; l++) begin
         rd(12'(SLES_LANE4_ERROR_STATUS + l), exp_st[l]);
         chk("lane_status", exp_st[l], lane_status[l]);
      end
   endtask

   // Gaps between pulses keep every event a distinct one-cycle pulse
   task automatic pulse_err(input int l, input int k, input int n);
      repeat (n) begin
         lane_in[l].error[k] = 1'b1;
         tick();
         lane_in[l].error[k] = 1'b0;
         tick();
      end
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      print_verdict();
   end

   initial begin
      ref_clk = 0; rst_n = 0; lane_in = '0; reg_addr = '0;
      reg_rd = 0; reg_wr = 0; reg_wdata = '0; exp_st = '{default: 8'h00};
      repeat (12) tick();
      rst_n = 1'b1;
      tick();
      check_all();
      rd(12'h498, 8'h00);
      rd(12'h493, 8'h00);
      $display("test reset_values done");
      for (int l = 0; l < 4; l++) begin
         lane_in[l].active = 1'b1;
         exp_st[l] = 8'h08;
         tick();
         tick();
         check_all();
      end
      lane_in[3].active = 1'b0;
      exp_st[3] = 8'h00;
      tick();
      tick();
      check_all();
      $display("test lane_active done");
      for (int k = 0; k < 3; k++) begin
         lane_in[1].hold[k] = k[0];
         pulse_err(1, k, 254);
         check_all();
         pulse_err(1, k, 1);
         exp_st[1][k] = 1'b1;
         check_all();
         pulse_err(1, k, 1);
         check_all();
      end
      $display("test count_full done");
      reg_addr = 12'h495;
      reg_wdata = 8'hff;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
      check_all();
      $display("test write_ignored done");
      for (int k = 0; k < 3; k++) begin
         lane_in[1].clear[k] = 1'b1;
         tick();
         lane_in[1].clear[k] = 1'b0;
         exp_st[1][k] = 1'b0;
         tick();
         tick();
         check_all();
      end
      $display("test clear done");
      print_verdict();
   end
endmodule
